// [src/clk_mode_pkg.sv]
// constants for the clock source and operating mode controller
package clk_mode_pkg;
    // oscillator nominal rates
    localparam int unsigned FAST_OSC_HZ     = 20_000_000;
    localparam int unsigned SLOW_OSC_HZ     = 32_000;
    localparam int unsigned CLK_HZ          = 20_000_000;
    // half slow clock period in fast cycles, rounded down
    localparam int unsigned SLOW_TICK_CYC   = CLK_HZ / (2 * SLOW_OSC_HZ);
    // oscillator settle times in microseconds and derived cycle counts
    localparam int unsigned FAST_SETTLE_US  = 16;
    localparam int unsigned SLOW_SETTLE_US  = 100;
    localparam int unsigned FAST_SETTLE_CYC = (FAST_SETTLE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SLOW_SETTLE_CYC = (SLOW_SETTLE_US * (CLK_HZ / 1_000_000));

    // register byte offsets
    localparam logic [7:0] MODE_REG_OFF = 8'h00;
    localparam logic [7:0] CTRL_REG_OFF = 8'h04;
    localparam logic [7:0] STAT_REG_OFF = 8'h08;
    localparam logic [7:0] HALT_REG_OFF = 8'h0C;

    // mode and control register fields
    localparam int FAST_SEL_BIT   = 0;
    localparam int IDLE_EN_BIT    = 1;
    localparam int FAST_RDY_BIT   = 2;
    localparam int SLOW_RDY_BIT   = 3;
    localparam int DIV_LSB        = 5;
    localparam int DIV_MSB        = 7;
    localparam int SYSCLK_KEEP_BIT = 7;
    localparam logic [2:0] DIV_RESET       = 3'h0;
    localparam logic       FAST_SEL_RESET  = 1'b1;
    localparam logic       IDLE_EN_RESET   = 1'b1;
    localparam logic       SYSCLK_KEEP_RESET = 1'b0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_SLOW,
        MODE_SLEEP,
        MODE_IDLE0,
        MODE_IDLE1
    } op_mode_e;
endpackage

// [src/clock_source_and_power_modes.sv]
// system clock source selection, glitch-free divider switching and operating modes
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module clock_source_and_power_modes #(
    parameter int unsigned FAST_SETTLE = clk_mode_pkg::FAST_SETTLE_CYC,
    parameter int unsigned SLOW_SETTLE = clk_mode_pkg::SLOW_SETTLE_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // cpu side
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    // clock enables standing for the gated clocks, and the operating mode
    output logic             system_clock,
    output logic             cpu_clock_en,
    output logic             timebase_clock,
    output logic             sub_clock,
    output logic             wdt_clock,
    output logic             fast_osc_on,
    output logic             fast_periph_en,
    output logic [2:0]       op_mode
);
    logic       rst_meta;
    logic       rst_sync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire logic rst_n = rst_sync;

    // ---------------- control bits
    logic       fast_clock_select;
    logic [2:0] sysclk_divider_field;
    logic       idle_on_halt_enable;
    logic       idle_sysclk_keep;
    logic       fast_osc_ready;
    logic       slow_osc_ready;
    clk_mode_pkg::op_mode_e mode;
    logic       src_slow;
    logic [6:0] src_ratio;

    // ---------------- axi4-lite write path
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire logic aw_now = aw_held || (s_axi_awvalid && s_axi_awready);
    wire logic w_now  = w_held || (s_axi_wvalid && s_axi_wready);
    wire logic [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire logic [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire logic wr_fire = aw_now && w_now && !s_axi_bvalid;

    function automatic logic known_addr(input logic [7:0] a);
        return a == clk_mode_pkg::MODE_REG_OFF || a == clk_mode_pkg::CTRL_REG_OFF
            || a == clk_mode_pkg::STAT_REG_OFF || a == clk_mode_pkg::HALT_REG_OFF;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= clk_mode_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(wr_addr) ? clk_mode_pkg::RESP_OKAY
                                                    : clk_mode_pkg::RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    wire logic mode_wr = wr_fire && wr_addr == clk_mode_pkg::MODE_REG_OFF && wr_strb[0];
    wire logic ctrl_wr = wr_fire && wr_addr == clk_mode_pkg::CTRL_REG_OFF && wr_strb[0];
    // a write of bit 0 to the halt register stands for the halt instruction
    wire logic halt_wr = wr_fire && wr_addr == clk_mode_pkg::HALT_REG_OFF && wr_strb[0]
                         && wr_data[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_clock_select    <= clk_mode_pkg::FAST_SEL_RESET;
            sysclk_divider_field <= clk_mode_pkg::DIV_RESET;
            idle_on_halt_enable  <= clk_mode_pkg::IDLE_EN_RESET;
            idle_sysclk_keep     <= clk_mode_pkg::SYSCLK_KEEP_RESET;
        end else begin
            if (mode_wr) begin
                fast_clock_select    <= wr_data[clk_mode_pkg::FAST_SEL_BIT];
                idle_on_halt_enable  <= wr_data[clk_mode_pkg::IDLE_EN_BIT];
                sysclk_divider_field <= wr_data[clk_mode_pkg::DIV_MSB:clk_mode_pkg::DIV_LSB];
            end
            if (ctrl_wr) begin
                idle_sysclk_keep <= wr_data[clk_mode_pkg::SYSCLK_KEEP_BIT];
            end
        end
    end

    // ---------------- axi4-lite read path
    logic [7:0] mode_byte;

    always_comb begin
        mode_byte = 8'h00;
        mode_byte[clk_mode_pkg::DIV_MSB:clk_mode_pkg::DIV_LSB] = sysclk_divider_field;
        mode_byte[clk_mode_pkg::SLOW_RDY_BIT] = slow_osc_ready;
        mode_byte[clk_mode_pkg::FAST_RDY_BIT] = fast_osc_ready;
        mode_byte[clk_mode_pkg::IDLE_EN_BIT]  = idle_on_halt_enable;
        mode_byte[clk_mode_pkg::FAST_SEL_BIT] = fast_clock_select;
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= clk_mode_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known_addr(s_axi_araddr) ? clk_mode_pkg::RESP_OKAY
                                                     : clk_mode_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                clk_mode_pkg::MODE_REG_OFF: s_axi_rdata <= {24'h000000, mode_byte};
                clk_mode_pkg::CTRL_REG_OFF: s_axi_rdata <= {24'h000000, idle_sysclk_keep,
                                                            7'h00};
                clk_mode_pkg::STAT_REG_OFF: s_axi_rdata <= {29'h00000000, op_mode};
                default:                    s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- source selection
    function automatic logic [6:0] ratio_of(input logic sel, input logic [2:0] div);
        if (sel) begin
            return 7'h01;
        end
        unique case (div)
            3'h0, 3'h1: return 7'h00;
            3'h2:       return 7'h40;
            3'h3:       return 7'h20;
            3'h4:       return 7'h10;
            3'h5:       return 7'h08;
            3'h6:       return 7'h04;
            default:    return 7'h02;
        endcase
    endfunction

    // zero ratio means the slow clock is the source
    wire logic [6:0] want_ratio = ratio_of(fast_clock_select, sysclk_divider_field);
    wire logic want_slow = want_ratio == 7'h00;

    // ---------------- operating mode
    wire logic cpu_running = mode == clk_mode_pkg::MODE_NORMAL
                          || mode == clk_mode_pkg::MODE_SLOW;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= clk_mode_pkg::MODE_NORMAL;
        end else begin
            unique case (mode)
                clk_mode_pkg::MODE_NORMAL, clk_mode_pkg::MODE_SLOW: begin
                    if (halt_req || halt_wr) begin
                        if (!idle_on_halt_enable) begin
                            mode <= clk_mode_pkg::MODE_SLEEP;
                        end else if (!idle_sysclk_keep) begin
                            mode <= clk_mode_pkg::MODE_IDLE0;
                        end else begin
                            mode <= clk_mode_pkg::MODE_IDLE1;
                        end
                    end else begin
                        mode <= src_slow ? clk_mode_pkg::MODE_SLOW : clk_mode_pkg::MODE_NORMAL;
                    end
                end
                clk_mode_pkg::MODE_SLEEP, clk_mode_pkg::MODE_IDLE0,
                clk_mode_pkg::MODE_IDLE1: begin
                    if (wake_req) begin
                        mode <= src_slow ? clk_mode_pkg::MODE_SLOW : clk_mode_pkg::MODE_NORMAL;
                    end
                end
                default: mode <= clk_mode_pkg::MODE_NORMAL;
            endcase
        end
    end

    assign op_mode = mode;

    // ---------------- oscillators
    // fast oscillator runs while a fast source is wanted or in use, in normal, slow and idle1 only
    wire logic fast_needed = (!want_slow || !src_slow)
                          && (cpu_running || (mode == clk_mode_pkg::MODE_IDLE1));
    logic [31:0] fast_settle_cnt;
    logic [31:0] slow_settle_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_settle_cnt <= 32'h0000_0000;
            fast_osc_ready  <= 1'b0;
        end else if (!fast_needed) begin
            fast_settle_cnt <= 32'h0000_0000;
            fast_osc_ready  <= 1'b0;
        end else if (fast_settle_cnt >= FAST_SETTLE) begin
            fast_osc_ready  <= 1'b1;
        end else begin
            fast_settle_cnt <= fast_settle_cnt + 32'h0000_0001;
        end
    end

    // slow rc never stops: it feeds watchdog and substitute in every mode, and time base in every mode but sleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_settle_cnt <= 32'h0000_0000;
            slow_osc_ready  <= 1'b0;
        end else if (slow_settle_cnt >= SLOW_SETTLE) begin
            slow_osc_ready  <= 1'b1;
        end else begin
            slow_settle_cnt <= slow_settle_cnt + 32'h0000_0001;
        end
    end

    assign fast_osc_on = fast_needed;

    // slow clock modelled as a 32kHz toggle derived from the 20MHz reference
    logic [9:0] slow_cnt;
    logic       slow_clk;
    logic       slow_tick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt  <= 10'h000;
            slow_clk  <= 1'b0;
            slow_tick <= 1'b0;
        end else if (slow_cnt == 10'(clk_mode_pkg::SLOW_TICK_CYC - 1)) begin
            slow_cnt  <= 10'h000;
            slow_clk  <= !slow_clk;
            slow_tick <= !slow_clk;
        end else begin
            slow_cnt  <= slow_cnt + 10'h001;
            slow_tick <= 1'b0;
        end
    end

    // ---------------- glitch-free divided fast clock
    // changes take effect only at the end of a whole output period; a switch to the slow clock can still leave a short low pulse
    logic [5:0] div_cnt;
    logic       fast_div_clk;

    wire logic [5:0] half_m1 = 6'((src_ratio >> 1) - 7'h01);
    wire logic period_end = src_slow ? (slow_tick == 1'b0 && slow_cnt == 10'h000 && !slow_clk)
                          : (src_ratio == 7'h01) ? 1'b1
                          : (fast_div_clk && div_cnt == half_m1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_ratio <= 7'h01;
            src_slow  <= 1'b0;
        end else if (period_end && (want_slow || fast_osc_ready)) begin
            src_ratio <= want_ratio;
            src_slow  <= want_slow;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt      <= 6'h00;
            fast_div_clk <= 1'b0;
        end else if (src_slow || src_ratio == 7'h01) begin
            div_cnt      <= 6'h00;
            fast_div_clk <= 1'b0;
        end else if (div_cnt == half_m1) begin
            div_cnt      <= 6'h00;
            fast_div_clk <= !fast_div_clk;
        end else begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    wire logic sys_src = src_slow ? slow_clk : (src_ratio == 7'h01) ? 1'b1 : fast_div_clk;
    wire logic sys_on  = cpu_running || mode == clk_mode_pkg::MODE_IDLE1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            system_clock   <= 1'b0;
            cpu_clock_en   <= 1'b0;
            timebase_clock <= 1'b0;
            sub_clock      <= 1'b0;
            wdt_clock      <= 1'b0;
            fast_periph_en <= 1'b0;
        end else begin
            system_clock   <= sys_on && sys_src;
            cpu_clock_en   <= cpu_running;
            timebase_clock <= (mode != clk_mode_pkg::MODE_SLEEP) && slow_clk;
            sub_clock      <= slow_clk;
            wdt_clock      <= slow_clk;
            fast_periph_en <= !src_slow && sys_on;
        end
    end
endmodule

// [verif/clock_source_and_power_modes_assertions.sv]
// concurrent checks on the clock mode controller ports
`timescale 1ns/1ps
module clock_source_and_power_modes_assertions #(
    parameter int unsigned FAST_SETTLE = 4,
    parameter int unsigned SLOW_SETTLE = 4
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        cpu_clock_en,
    input wire logic        timebase_clock,
    input wire logic        sub_clock,
    input wire logic        wdt_clock,
    input wire logic        fast_osc_on,
    input wire logic        fast_periph_en,
    input wire logic [2:0]  op_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence halted;
        (op_mode >= 3'h2) [*2];
    endsequence
    // registered outputs may trail the mode by a cycle, so the mode must have settled
    sequence in_slow;
        (op_mode == 3'h1) [*3];
    endsequence

    a_write_answer: assert property (both_taken |=> s_axi_bvalid)
        else $error("write response not given one cycle after address and data");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response not given one cycle after address");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_mode_legal: assert property (op_mode <= 3'h4)
        else $error("operating mode outside the five modes");
    a_halt_cpu_off: assert property (halted |-> !cpu_clock_en)
        else $error("cpu clock running in a halted mode");
    a_sleep_tb_off: assert property ((op_mode == 3'h2) [*2] |-> !timebase_clock)
        else $error("time-base clock running in sleep");
    a_slow_fast_off: assert property (in_slow |-> !fast_periph_en)
        else $error("divided fast clocks running in slow mode");
    // in slow mode the fast oscillator may only warm up ahead of a switch back, so it is bounded
    a_fast_start_ends: assert property (op_mode == 3'h1 && fast_osc_on |->
        ##[1:1000] (op_mode != 3'h1 || !fast_osc_on))
        else $error("fast oscillator left running in slow mode");
    a_slow_runs: assert property (##1 1'b1 |-> ##[1:700]
        (sub_clock != $past(sub_clock) && wdt_clock != $past(wdt_clock)))
        else $error("substitute or watchdog clock stalled");
endmodule

bind clock_source_and_power_modes clock_source_and_power_modes_assertions #(
    .FAST_SETTLE(FAST_SETTLE),
    .SLOW_SETTLE(SLOW_SETTLE)
) u_chk (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cpu_clock_en(cpu_clock_en), .timebase_clock(timebase_clock),
    .sub_clock(sub_clock), .wdt_clock(wdt_clock), .fast_osc_on(fast_osc_on),
    .fast_periph_en(fast_periph_en), .op_mode(op_mode)
);

// [verif/clock_source_and_power_modes_tb.sv]
// self-checking bench for the clock source and operating mode controller
`timescale 1ns/1ps
module clock_source_and_power_modes_tb;
    logic        clk = 1'b0, arst_n = 1'b0, halt_req = 1'b0, wake_req = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, system_clock, cpu_clock_en;
    logic        timebase_clock, sub_clock, wdt_clock, fast_osc_on, fast_periph_en, seen;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  op_mode;
    int          bad_count = 0, n_tests = 0, cyc = 0, p, c, fs, slow, off;

    always #25 clk = ~clk;

    clock_source_and_power_modes #(.FAST_SETTLE(4), .SLOW_SETTLE(4)) dut (
        .clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .halt_req(halt_req), .wake_req(wake_req), .system_clock(system_clock),
        .cpu_clock_en(cpu_clock_en), .timebase_clock(timebase_clock), .sub_clock(sub_clock),
        .wdt_clock(wdt_clock), .fast_osc_on(fast_osc_on), .fast_periph_en(fast_periph_en),
        .op_mode(op_mode)
    );

    task automatic test_done();
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake ends the run here rather than stalling forever
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic got;
        got = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                got = 1'b1;
                bready <= 1'b0;
            end
        end
        // one idle edge keeps the next request off this release
        @(posedge clk);
    endtask

    task automatic axr(input logic [7:0] a);
        logic got;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                got = 1'b1;
                rready <= 1'b0;
            end
        end
        @(posedge clk);
    endtask

    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (op_mode !== m && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(op_mode), 32'(m));
    endtask

    // period between the second and third rising edge; 0 if the line never toggles
    task automatic per(input int s, output int q);
        logic prev, cur;
        int n, rises, mark;
        n = 0;
        rises = 0;
        mark = 0;
        q = 0;
        prev = 1'b1;
        while (q == 0 && n < 3000) begin
            @(posedge clk);
            n++;
            cur = (s == 0) ? system_clock : sub_clock;
            if (cur === 1'b1 && prev === 1'b0) begin
                rises++;
                if (rises == 2) mark = n;
                if (rises == 3) q = n - mark;
            end
            prev = cur;
        end
    endtask

    task automatic pulse(input int w);
        if (w == 0) halt_req <= 1'b1;
        else wake_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask

    initial begin
        void'($urandom(34346));
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (24) @(posedge clk);
        axr(clk_mode_pkg::MODE_REG_OFF);
        chk(d, 32'h0000_000F);
        axr(clk_mode_pkg::CTRL_REG_OFF);
        chk(d, 32'h0);
        axr(clk_mode_pkg::STAT_REG_OFF);
        chk(d, 32'h0);
        axr(8'h10);
        chk({30'h0, r}, {30'h0, clk_mode_pkg::RESP_SLVERR});
        chk(d, 32'h0);
        axw(8'h10, 32'h0000_00FF);
        chk({30'h0, r}, {30'h0, clk_mode_pkg::RESP_SLVERR});
        off = $urandom % 8;
        for (int i = 0; i < 9; i++) begin
            c = (i + off) % 8;
            fs = (i == 8) ? 1 : 0;
            slow = (fs == 0 && c < 2) ? 1 : 0;
            axw(clk_mode_pkg::MODE_REG_OFF, 32'(c * 32 + fs));
            wait_mode(slow ? 3'h1 : 3'h0);
            per(0, p);
            chk(p, fs ? 0 : slow ? 2 * clk_mode_pkg::SLOW_TICK_CYC : 1 << (8 - c));
            chk({fast_osc_on, fast_periph_en}, slow ? 32'h0 : 32'h3);
            axr(clk_mode_pkg::MODE_REG_OFF);
            chk(d, 32'(c * 32 + 8 + (slow ? 0 : 4) + fs));
        end
        per(1, p);
        chk(p, 2 * clk_mode_pkg::SLOW_TICK_CYC);
        for (int k = 0; k < 3; k++) begin
            axw(clk_mode_pkg::CTRL_REG_OFF, (k == 2) ? 32'h80 : 32'h0);
            axw(clk_mode_pkg::MODE_REG_OFF, (k > 0) ? 32'h3 : 32'h1);
            if (k == 1) axw(clk_mode_pkg::HALT_REG_OFF, 32'h1);
            else pulse(0);
            wait_mode(3'(2 + k));
            // the cpu enable is registered one stage behind the mode
            @(posedge clk);
            chk(32'(cpu_clock_en), 32'h0);
            seen = 1'b0;
            repeat (700) begin
                @(posedge clk);
                if (timebase_clock === 1'b1) seen = 1'b1;
            end
            chk(32'(seen), (k == 0) ? 32'h0 : 32'h1);
            chk({system_clock, fast_osc_on, fast_periph_en}, (k == 2) ? 32'h7 : 32'h0);
            axr(clk_mode_pkg::STAT_REG_OFF);
            chk(d, 32'(2 + k));
            pulse(1);
            wait_mode(3'h0);
        end
        test_done();
    end
endmodule
